// ==== pkg/afe_pkg.sv ====
// Package for the front-end configuration register bank.
// Assumes a single 25 MHz clock and serial pins already synchronous to it.
package afe_pkg;
   // Register addresses, 13-bit as carried in the instruction header
   localparam logic [12:0] ADDR_INTERFACE_FORMAT = 13'h0000;
   localparam logic [12:0] ADDR_DEFAULT_TRIGGER = 13'h0001;
   localparam logic [12:0] ADDR_PART_CODE_LOW = 13'h0004;
   localparam logic [12:0] ADDR_PART_CODE_HIGH = 13'h0005;
   localparam logic [12:0] ADDR_SILICON_REVISION = 13'h0006;
   localparam logic [12:0] ADDR_OFFSET_TRIM_CH_A = 13'h0010;
   localparam logic [12:0] ADDR_OFFSET_TRIM_CH_B = 13'h0011;
   localparam logic [12:0] ADDR_OFFSET_TRIM_CH_C = 13'h0012;
   localparam logic [12:0] ADDR_OFFSET_TRIM_CH_D = 13'h0013;
   localparam logic [12:0] ADDR_STAGE_BIAS_MODES = 13'h0014;
   localparam logic [12:0] ADDR_CHANNEL_GAIN_CODES = 13'h0015;
   localparam logic [12:0] ADDR_CHANNEL_ENABLES = 13'h0017;
   localparam logic [12:0] ADDR_BIAS_GENERATOR_ENABLE = 13'h0018;
   localparam logic [12:0] ADDR_SPARE_PIN_WRITE = 13'h001D;
   localparam logic [12:0] ADDR_SPARE_PIN_READ = 13'h001E;

   // Values after reset
   localparam logic [7:0] RST_INTERFACE_FORMAT = 8'h00;
   localparam logic [5:0] RST_OFFSET_TRIM = 6'h20;
   localparam logic [3:0] RST_STAGE_BIAS_MODES = 4'hA;
   localparam logic [7:0] RST_CHANNEL_GAIN_CODES = 8'h00;
   localparam logic [3:0] RST_CHANNEL_ENABLES = 4'h0;
   localparam logic [0:0] RST_BIAS_GENERATOR_ENABLE = 1'h0;
   localparam logic [1:0] RST_SPARE_PIN_WRITE = 2'h0;
   localparam logic [0:0] RST_SPARE_PIN_READ = 1'h0;

   // Field positions
   localparam int BIT_ORDER_UPPER_POS = 5;
   localparam int BIT_ORDER_LOWER_POS = 2;
   localparam int DEFAULT_TRIGGER_POS = 0;
   localparam int SPARE_MODE_POS = 0;
   localparam int SPARE_VALUE_POS = 1;
   localparam int HDR_READ_POS = 15;

   // Frame lengths in serial clock edges
   localparam logic [4:0] HEADER_BITS = 5'h10;
   localparam logic [4:0] FRAME_BITS = 5'h18;

   typedef enum logic [1:0] {
      AFE_ST_IDLE = 2'b00,
      AFE_ST_HEADER = 2'b01,
      AFE_ST_DATA = 2'b10,
      AFE_ST_DONE = 2'b11
   } afe_spi_state_t;
endpackage

// ==== rtl/afe_control_register_bank.sv ====
// Configuration register bank of a four-channel receive front end, with its serial port.
// Assumes spi_* pins synchronous to clk and serial clock below half the clk rate.
`timescale 1ns/1ps

// Summary of operation
// - Self-reset bit restores all register defaults
// - Bit-order copies: one LSB first, zero MSB
// - Format register mirror-symmetric, written first by host
// - Four 6-bit offset trims, reset 0x20
// - Bias register two 2-bit modes, reset 0x0A
// - Gain register four 2-bit codes, reset zero
// - Channel enables bits 3:0, reset zero
// - Bias generator enable bit 0, reset zero
// - Two read-only part code bytes
// - Read-only revision register reads zero
// - Spare write: mode bit 0, value bit 1
// - Spare read reports sampled pin at bit 0
// - 16-bit header then eight data bits
// - Gain code per channel at ascending bit pairs
module afe_control_register_bank
   import afe_pkg::*;
#(
   parameter logic [7:0] PART_CODE_LOW_VALUE = 8'h5A,  // Arbitrary value
   parameter logic [7:0] PART_CODE_HIGH_VALUE = 8'hC3, // Arbitrary value
   parameter logic [7:0] SILICON_REVISION_VALUE = 8'h00
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic spi_cs_n,
   input wire logic spi_sclk,
   input wire logic spi_sdi,
   output logic spi_sdo,
   output logic spi_sdo_oe,
   input wire logic spare_pin_in,
   output logic spare_pin_out,
   output logic spare_pin_oe,
   output logic [5:0] offset_trim_ch_a,
   output logic [5:0] offset_trim_ch_b,
   output logic [5:0] offset_trim_ch_c,
   output logic [5:0] offset_trim_ch_d,
   output logic [1:0] second_stage_bias_mode,
   output logic [1:0] first_stage_bias_mode,
   output logic [1:0] gain_code_ch_a,
   output logic [1:0] gain_code_ch_b,
   output logic [1:0] gain_code_ch_c,
   output logic [1:0] gain_code_ch_d,
   output logic [3:0] channel_enables,
   output logic bias_generator_enable
);

   // Register state
   logic [7:0] format_reg, format_next;
   logic srst_reg, srst_next;
   logic [5:0] trim_reg [4];
   logic [5:0] trim_next [4];
   logic [3:0] bias_reg, bias_next;
   logic [7:0] gain_reg, gain_next;
   logic [3:0] chen_reg, chen_next;
   logic [0:0] bgen_reg, bgen_next;
   logic [1:0] spare_wr_reg, spare_wr_next;
   logic [0:0] spare_rd_reg, spare_rd_next;

   // Serial engine state
   afe_spi_state_t state_reg, state_next;
   logic sclk_q_reg, sclk_q_next;
   logic [4:0] cnt_reg, cnt_next;
   logic [15:0] shift_reg, shift_next;
   logic is_read_reg, is_read_next;
   logic [12:0] addr_reg, addr_next;
   logic [7:0] rd_sh_reg, rd_sh_next;
   logic sdo_reg, sdo_next;
   logic oe_reg, oe_next;
   logic wr_stb_reg, wr_stb_next;
   logic [7:0] wr_data_reg, wr_data_next;

   logic lsb_first;
   logic sclk_rise;
   logic sclk_fall;

   // Mirrored copies swap places under a wrong order, so either one selects it
   assign lsb_first = format_reg[BIT_ORDER_UPPER_POS] | format_reg[BIT_ORDER_LOWER_POS];
   assign sclk_rise = spi_sclk & ~sclk_q_reg;
   assign sclk_fall = ~spi_sclk & sclk_q_reg;

   // One serial bit into the shift register, in the selected order
   function automatic logic [15:0] shift_in(input logic [15:0] old, input logic din,
                                            input logic lsb);
      if (lsb) begin
         shift_in = {din, old[15:1]};
      end else begin
         shift_in = {old[14:0], din};
      end
   endfunction

   // Read-back mux; unmapped addresses and unused bits give zero
   function automatic logic [7:0] read_value(input logic [12:0] a);
      case (a)
         ADDR_INTERFACE_FORMAT: read_value = format_reg;
         ADDR_DEFAULT_TRIGGER: read_value = {7'h00, srst_reg};
         ADDR_PART_CODE_LOW: read_value = PART_CODE_LOW_VALUE;
         ADDR_PART_CODE_HIGH: read_value = PART_CODE_HIGH_VALUE;
         ADDR_SILICON_REVISION: read_value = SILICON_REVISION_VALUE;
         ADDR_OFFSET_TRIM_CH_A: read_value = {2'h0, trim_reg[0]};
         ADDR_OFFSET_TRIM_CH_B: read_value = {2'h0, trim_reg[1]};
         ADDR_OFFSET_TRIM_CH_C: read_value = {2'h0, trim_reg[2]};
         ADDR_OFFSET_TRIM_CH_D: read_value = {2'h0, trim_reg[3]};
         ADDR_STAGE_BIAS_MODES: read_value = {4'h0, bias_reg};
         ADDR_CHANNEL_GAIN_CODES: read_value = gain_reg;
         ADDR_CHANNEL_ENABLES: read_value = {4'h0, chen_reg};
         ADDR_BIAS_GENERATOR_ENABLE: read_value = {7'h00, bgen_reg};
         ADDR_SPARE_PIN_WRITE: read_value = {6'h00, spare_wr_reg};
         ADDR_SPARE_PIN_READ: read_value = {7'h00, spare_rd_reg};
         default: read_value = 8'h00;
      endcase
   endfunction

   // Serial frame engine: header, then one data byte
   always_comb begin
      logic [15:0] sh;
      sh = shift_in(shift_reg, spi_sdi, lsb_first);
      state_next = state_reg;
      sclk_q_next = spi_sclk;
      cnt_next = cnt_reg;
      shift_next = shift_reg;
      is_read_next = is_read_reg;
      addr_next = addr_reg;
      rd_sh_next = rd_sh_reg;
      sdo_next = sdo_reg;
      oe_next = oe_reg;
      wr_stb_next = 1'b0;
      wr_data_next = wr_data_reg;
      if (spi_cs_n) begin
         // Deselect aborts any partial frame; nothing is written
         state_next = AFE_ST_IDLE;
         cnt_next = 5'h00;
         sdo_next = 1'b0;
         oe_next = 1'b0;
      end else begin
         case (state_reg)
            AFE_ST_IDLE: begin
               state_next = AFE_ST_HEADER;
               cnt_next = 5'h00;
            end
            AFE_ST_HEADER: begin
               if (sclk_rise) begin
                  shift_next = sh;
                  cnt_next = cnt_reg + 5'h01;
                  if (cnt_reg == HEADER_BITS - 5'h01) begin
                     // Byte count bits are not acted on: one register per frame
                     is_read_next = sh[HDR_READ_POS];
                     addr_next = sh[12:0];
                     rd_sh_next = read_value(sh[12:0]);
                     oe_next = sh[HDR_READ_POS];
                     state_next = AFE_ST_DATA;
                  end
               end
            end
            AFE_ST_DATA: begin
               if (sclk_rise) begin
                  shift_next = sh;
                  cnt_next = cnt_reg + 5'h01;
                  if (cnt_reg == FRAME_BITS - 5'h01) begin
                     state_next = AFE_ST_DONE;
                     wr_stb_next = ~is_read_reg;
                     wr_data_next = lsb_first ? sh[15:8] : sh[7:0];
                  end
               end
               // Read data changes on the falling edge for the host to sample on rising
               if (sclk_fall && is_read_reg) begin
                  if (lsb_first) begin
                     sdo_next = rd_sh_reg[0];
                     rd_sh_next = {1'b0, rd_sh_reg[7:1]};
                  end else begin
                     sdo_next = rd_sh_reg[7];
                     rd_sh_next = {rd_sh_reg[6:0], 1'b0};
                  end
               end
            end
            AFE_ST_DONE: begin
               // Extra clocks ignored until deselect
               state_next = AFE_ST_DONE;
            end
            default: begin
               state_next = AFE_ST_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         state_reg <= AFE_ST_IDLE;
         sclk_q_reg <= 1'b0;
         cnt_reg <= 5'h00;
         shift_reg <= 16'h0000;
         is_read_reg <= 1'b0;
         addr_reg <= 13'h0000;
         rd_sh_reg <= 8'h00;
         sdo_reg <= 1'b0;
         oe_reg <= 1'b0;
         wr_stb_reg <= 1'b0;
         wr_data_reg <= 8'h00;
      end else begin
         state_reg <= state_next;
         sclk_q_reg <= sclk_q_next;
         cnt_reg <= cnt_next;
         shift_reg <= shift_next;
         is_read_reg <= is_read_next;
         addr_reg <= addr_next;
         rd_sh_reg <= rd_sh_next;
         sdo_reg <= sdo_next;
         oe_reg <= oe_next;
         wr_stb_reg <= wr_stb_next;
         wr_data_reg <= wr_data_next;
      end
   end

   // Register file: software reset first, then a completed write frame
   always_comb begin
      format_next = format_reg;
      srst_next = 1'b0;
      trim_next = trim_reg;
      bias_next = bias_reg;
      gain_next = gain_reg;
      chen_next = chen_reg;
      bgen_next = bgen_reg;
      spare_wr_next = spare_wr_reg;
      spare_rd_next = spare_pin_in;
      if (srst_reg) begin
         // Whole bank to defaults; the trigger itself drops here
         format_next = RST_INTERFACE_FORMAT;
         trim_next = '{4{RST_OFFSET_TRIM}};
         bias_next = RST_STAGE_BIAS_MODES;
         gain_next = RST_CHANNEL_GAIN_CODES;
         chen_next = RST_CHANNEL_ENABLES;
         bgen_next = RST_BIAS_GENERATOR_ENABLE;
         spare_wr_next = RST_SPARE_PIN_WRITE;
         srst_next = 1'b0;
      end else if (wr_stb_reg) begin
         case (addr_reg)
            ADDR_INTERFACE_FORMAT: format_next = wr_data_reg;
            ADDR_DEFAULT_TRIGGER: srst_next = wr_data_reg[DEFAULT_TRIGGER_POS];
            ADDR_OFFSET_TRIM_CH_A: trim_next[0] = wr_data_reg[5:0];
            ADDR_OFFSET_TRIM_CH_B: trim_next[1] = wr_data_reg[5:0];
            ADDR_OFFSET_TRIM_CH_C: trim_next[2] = wr_data_reg[5:0];
            ADDR_OFFSET_TRIM_CH_D: trim_next[3] = wr_data_reg[5:0];
            ADDR_STAGE_BIAS_MODES: bias_next = wr_data_reg[3:0];
            ADDR_CHANNEL_GAIN_CODES: gain_next = wr_data_reg;
            ADDR_CHANNEL_ENABLES: chen_next = wr_data_reg[3:0];
            ADDR_BIAS_GENERATOR_ENABLE: bgen_next = wr_data_reg[0:0];
            ADDR_SPARE_PIN_WRITE: spare_wr_next = wr_data_reg[1:0];
            default: begin
               // Read-only and unmapped addresses drop the data
               format_next = format_reg;
            end
         endcase
      end
   end

   // Hardware reset pin and storage
   always_ff @(posedge clk) begin
      if (reset) begin
         format_reg <= RST_INTERFACE_FORMAT;
         srst_reg <= 1'b0;
         trim_reg <= '{4{RST_OFFSET_TRIM}};
         bias_reg <= RST_STAGE_BIAS_MODES;
         gain_reg <= RST_CHANNEL_GAIN_CODES;
         chen_reg <= RST_CHANNEL_ENABLES;
         bgen_reg <= RST_BIAS_GENERATOR_ENABLE;
         spare_wr_reg <= RST_SPARE_PIN_WRITE;
         spare_rd_reg <= RST_SPARE_PIN_READ;
      end else begin
         format_reg <= format_next;
         srst_reg <= srst_next;
         trim_reg <= trim_next;
         bias_reg <= bias_next;
         gain_reg <= gain_next;
         chen_reg <= chen_next;
         bgen_reg <= bgen_next;
         spare_wr_reg <= spare_wr_next;
         spare_rd_reg <= spare_rd_next;
      end
   end

   // Outputs straight from flops; sharing an output bus is left to the system
   assign spi_sdo = sdo_reg;
   assign spi_sdo_oe = oe_reg;
   assign spare_pin_out = spare_wr_reg[SPARE_VALUE_POS];
   assign spare_pin_oe = spare_wr_reg[SPARE_MODE_POS];
   assign offset_trim_ch_a = trim_reg[0];
   assign offset_trim_ch_b = trim_reg[1];
   assign offset_trim_ch_c = trim_reg[2];
   assign offset_trim_ch_d = trim_reg[3];
   assign second_stage_bias_mode = bias_reg[3:2];
   assign first_stage_bias_mode = bias_reg[1:0];
   assign gain_code_ch_a = gain_reg[1:0];
   assign gain_code_ch_b = gain_reg[3:2];
   assign gain_code_ch_c = gain_reg[5:4];
   assign gain_code_ch_d = gain_reg[7:6];
   assign channel_enables = chen_reg;
   assign bias_generator_enable = bgen_reg[0];

endmodule

// ==== tb/afe_bank_checker.sv ====
// Port checks for the front-end register bank.
// Assumes one clock domain with a synchronous active-high reset.
`timescale 1ns/1ps
module afe_bank_checker
   import afe_pkg::*;
(
   input wire logic clk,
   input wire logic reset,
   input wire logic spi_cs_n,
   input wire logic spi_sclk,
   input wire logic spi_sdo,
   input wire logic spi_sdo_oe,
   input wire logic spare_pin_out,
   input wire logic spare_pin_oe,
   input wire logic [5:0] offset_trim_ch_a,
   input wire logic [5:0] offset_trim_ch_d,
   input wire logic [1:0] second_stage_bias_mode,
   input wire logic [1:0] first_stage_bias_mode,
   input wire logic [1:0] gain_code_ch_a,
   input wire logic [1:0] gain_code_ch_d,
   input wire logic [3:0] channel_enables,
   input wire logic bias_generator_enable
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);
   // Settings gathered so that one check covers them all, except the channel B and C trims and gains
   logic [26:0] cfg;
   assign cfg = {offset_trim_ch_a, offset_trim_ch_d, second_stage_bias_mode,
      first_stage_bias_mode, gain_code_ch_a, gain_code_ch_d, channel_enables,
      bias_generator_enable, spare_pin_out, spare_pin_oe};
   // Five clocks deselected: even a self reset has landed by then
   sequence s_deselected;
      spi_cs_n [*5];
   endsequence
   sequence s_released;
      spi_cs_n [*3];
   endsequence
   property p_rst_trims;
      $fell(reset) |-> offset_trim_ch_a == RST_OFFSET_TRIM && offset_trim_ch_d == RST_OFFSET_TRIM
         && {second_stage_bias_mode, first_stage_bias_mode} == RST_STAGE_BIAS_MODES;
   endproperty
   a_rst_trims: assert property (p_rst_trims) else $error("trim or bias default wrong");
   property p_rst_ctrl;
      $fell(reset) |-> {gain_code_ch_a, gain_code_ch_d, channel_enables, bias_generator_enable,
         spare_pin_out, spare_pin_oe, spi_sdo_oe} == 12'h000;
   endproperty
   a_rst_ctrl: assert property (p_rst_ctrl) else $error("control default wrong");
   property p_hold;
      s_deselected |-> $stable(cfg);
   endproperty
   a_hold: assert property (p_hold) else $error("setting moved while idle");
   property p_cause;
      $changed(cfg) |-> !$past(spi_cs_n, 2) || !$past(spi_cs_n, 3);
   endproperty
   a_cause: assert property (p_cause) else $error("setting moved without a frame");
   property p_oe_off;
      s_released |-> !spi_sdo_oe && !spi_sdo;
   endproperty
   a_oe_off: assert property (p_oe_off) else $error("read line driven while idle");
   property p_oe_hold;
      spi_sdo_oe && !spi_cs_n |=> spi_sdo_oe;
   endproperty
   a_oe_hold: assert property (p_oe_hold) else $error("read enable dropped mid frame");
   property p_oe_rise;
      $rose(spi_sdo_oe) |-> !$past(spi_cs_n) && $past(spi_sclk);
   endproperty
   a_oe_rise: assert property (p_oe_rise) else $error("read enable without clock rise");
   property p_sdo_fall;
      spi_sdo_oe && $past(spi_sdo_oe) && $changed(spi_sdo) |-> !$past(spi_sclk)
         && $past(spi_sclk, 2);
   endproperty
   a_sdo_fall: assert property (p_sdo_fall) else $error("read bit not after a fall");
endmodule

bind afe_control_register_bank afe_bank_checker u_checker (
   .clk(clk),
   .reset(reset),
   .spi_cs_n(spi_cs_n),
   .spi_sclk(spi_sclk),
   .spi_sdo(spi_sdo),
   .spi_sdo_oe(spi_sdo_oe),
   .spare_pin_out(spare_pin_out),
   .spare_pin_oe(spare_pin_oe),
   .offset_trim_ch_a(offset_trim_ch_a),
   .offset_trim_ch_d(offset_trim_ch_d),
   .second_stage_bias_mode(second_stage_bias_mode),
   .first_stage_bias_mode(first_stage_bias_mode),
   .gain_code_ch_a(gain_code_ch_a),
   .gain_code_ch_d(gain_code_ch_d),
   .channel_enables(channel_enables),
   .bias_generator_enable(bias_generator_enable)
);

// ==== tb/afe_host_model.sv ====
// Serial host model: mode 0 frames, one register per frame.
// Assumes every call starts 1 ns after a rising clk edge.
`timescale 1ns/1ps
module afe_host_model (
   input wire logic clk,
   output logic spi_cs_n,
   output logic spi_sclk,
   output logic spi_sdi,
   input wire logic spi_sdo
);
   initial begin
      spi_cs_n = 1'b1;
      spi_sclk = 1'b0;
      spi_sdi = 1'b0;
   end
   // Three clocks per serial phase, above the two-clock minimum
   task automatic tick();
      repeat (3) @(posedge clk);
      #1;
   endtask
   // Frame of n rises; fewer than 24 models an aborted frame
   task automatic xfer(input logic rw, input logic [12:0] a, input logic [7:0] d,
         input logic lsb, input int n, output logic [7:0] q);
      logic [15:0] hdr;
      int k;
      hdr = {rw, 2'b00, a};
      q = 8'h00;
      spi_cs_n = 1'b0;
      for (int i = 0; i < n; i++) begin
         k = (i < 16) ? (lsb ? i : 15 - i) : (lsb ? i - 16 : 23 - i);
         spi_sdi = (i < 16) ? hdr[k] : d[k];
         tick();
         if (i > 15) q[k] = spi_sdo;
         spi_sclk = 1'b1;
         tick();
         spi_sclk = 1'b0;
      end
      tick();
      spi_cs_n = 1'b1;
      spi_sdi = ~spi_sdi; // Idle line must not look like stale data
      // Six deselected clocks, so the idle-hold check gets a real antecedent
      tick();
      tick();
   endtask
endmodule

// ==== tb/afe_control_register_bank_test.sv ====
// Self-checking bench for the front-end register bank.
// Assumes the serial host model and the bound port checker.
`timescale 1ns/1ps
module afe_control_register_bank_test;
   import afe_pkg::*;
   localparam logic [7:0] ID_LO = 8'h3C; // Arbitrary value
   localparam logic [7:0] ID_HI = 8'h96; // Arbitrary value
   localparam logic [23:0] TRIM_DEF = {4{RST_OFFSET_TRIM}};
   logic clk = 1'b0;
   logic reset = 1'b1;
   logic spare_pin_in = 1'b0;
   logic lsb = 1'b0;
   logic spi_cs_n, spi_sclk, spi_sdi, spi_sdo, spi_sdo_oe, spare_pin_out, spare_pin_oe;
   logic [5:0] offset_trim_ch_a, offset_trim_ch_b, offset_trim_ch_c, offset_trim_ch_d;
   logic [1:0] second_stage_bias_mode, first_stage_bias_mode;
   logic [1:0] gain_code_ch_a, gain_code_ch_b, gain_code_ch_c, gain_code_ch_d;
   logic [3:0] channel_enables;
   logic bias_generator_enable;
   int err_total = 0;
   int checks = 0;
   `define CHK(nm, ex, got) begin checks++; if ((got) !== (ex)) begin err_total++; \
      $display("BAD %s expected %h seen %h", nm, ex, got); end end
   always #20 clk = ~clk;
   afe_control_register_bank #(.PART_CODE_LOW_VALUE(ID_LO), .PART_CODE_HIGH_VALUE(ID_HI),
      .SILICON_REVISION_VALUE(8'h00)) u_dut (
      .clk(clk),
      .reset(reset),
      .spi_cs_n(spi_cs_n),
      .spi_sclk(spi_sclk),
      .spi_sdi(spi_sdi),
      .spi_sdo(spi_sdo),
      .spi_sdo_oe(spi_sdo_oe),
      .spare_pin_in(spare_pin_in),
      .spare_pin_out(spare_pin_out),
      .spare_pin_oe(spare_pin_oe),
      .offset_trim_ch_a(offset_trim_ch_a),
      .offset_trim_ch_b(offset_trim_ch_b),
      .offset_trim_ch_c(offset_trim_ch_c),
      .offset_trim_ch_d(offset_trim_ch_d),
      .second_stage_bias_mode(second_stage_bias_mode),
      .first_stage_bias_mode(first_stage_bias_mode),
      .gain_code_ch_a(gain_code_ch_a),
      .gain_code_ch_b(gain_code_ch_b),
      .gain_code_ch_c(gain_code_ch_c),
      .gain_code_ch_d(gain_code_ch_d),
      .channel_enables(channel_enables),
      .bias_generator_enable(bias_generator_enable)
   );
   afe_host_model u_host (.clk, .spi_cs_n, .spi_sclk, .spi_sdi, .spi_sdo);
   task automatic wr(input logic [12:0] a, input logic [7:0] d);
      logic [7:0] r;
      u_host.xfer(1'b0, a, d, lsb, 24, r);
   endtask
   task automatic rd(input logic [12:0] a, input logic [7:0] ex);
      logic [7:0] r;
      u_host.xfer(1'b1, a, 8'h00, lsb, 24, r);
      `CHK("read data", ex, r)
   endtask
   // Every setting output against one expected set
   task automatic outs(input logic [23:0] t, input logic [3:0] bm, input logic [7:0] g,
         input logic [3:0] en, input logic [2:0] misc);
      `CHK("trims", t, {offset_trim_ch_d, offset_trim_ch_c, offset_trim_ch_b, offset_trim_ch_a})
      `CHK("bias modes", bm, {second_stage_bias_mode, first_stage_bias_mode})
      `CHK("gains", g, {gain_code_ch_d, gain_code_ch_c, gain_code_ch_b, gain_code_ch_a})
      `CHK("enables", en, channel_enables)
      `CHK("gen and spare", misc, {bias_generator_enable, spare_pin_out, spare_pin_oe})
   endtask
   task automatic t_defaults();
      wr(ADDR_INTERFACE_FORMAT, 8'h00);
      outs(TRIM_DEF, RST_STAGE_BIAS_MODES, 8'h00, 4'h0, 3'b000);
      rd(ADDR_OFFSET_TRIM_CH_C, 8'h20);
      rd(ADDR_STAGE_BIAS_MODES, 8'h0A);
      rd(ADDR_PART_CODE_LOW, ID_LO);
      rd(ADDR_PART_CODE_HIGH, ID_HI);
      rd(ADDR_SILICON_REVISION, 8'h00);
      rd(ADDR_DEFAULT_TRIGGER, 8'h00);
   endtask
   // Ones in unused setting bits, three read-only places and one unmapped address, which must not keep them
   task automatic t_write_mask();
      for (int i = 0; i < 4; i++) begin
         wr(13'(ADDR_OFFSET_TRIM_CH_A + i), 8'hC0 | 8'(i + 1));
      end
      wr(ADDR_STAGE_BIAS_MODES, 8'hF6);
      wr(ADDR_CHANNEL_GAIN_CODES, 8'hE4);
      wr(ADDR_CHANNEL_ENABLES, 8'hF5);
      wr(ADDR_BIAS_GENERATOR_ENABLE, 8'hFF);
      wr(ADDR_SPARE_PIN_WRITE, 8'hFE);
      wr(ADDR_PART_CODE_HIGH, 8'hFF);
      wr(ADDR_SILICON_REVISION, 8'hFF);
      wr(ADDR_SPARE_PIN_READ, 8'hFF);
      wr(13'h0007, 8'hFF);
      outs(24'h103081, 4'h6, 8'hE4, 4'h5, 3'b110);
      rd(ADDR_OFFSET_TRIM_CH_B, 8'h02);
      rd(ADDR_STAGE_BIAS_MODES, 8'h06);
      rd(ADDR_CHANNEL_ENABLES, 8'h05);
      rd(ADDR_SPARE_PIN_WRITE, 8'h02);
      rd(ADDR_PART_CODE_HIGH, ID_HI);
      rd(ADDR_SILICON_REVISION, 8'h00);
      rd(13'h0007, 8'h00);
      spare_pin_in = 1'b1;
      rd(ADDR_SPARE_PIN_READ, 8'h01);
      spare_pin_in = 1'b0;
      rd(ADDR_SPARE_PIN_READ, 8'h00);
   endtask
   // One rise short of a frame must leave the enables alone
   task automatic t_abort();
      logic [7:0] r;
      u_host.xfer(1'b0, ADDR_CHANNEL_ENABLES, 8'h0A, lsb, 23, r);
      rd(ADDR_CHANNEL_ENABLES, 8'h05);
   endtask
   task automatic t_lsb_soft();
      wr(ADDR_INTERFACE_FORMAT, 8'h24);
      lsb = 1'b1;
      wr(ADDR_CHANNEL_GAIN_CODES, 8'h1B);
      `CHK("gains lsb", 8'h1B, {gain_code_ch_d, gain_code_ch_c, gain_code_ch_b, gain_code_ch_a})
      rd(ADDR_OFFSET_TRIM_CH_D, 8'h04);
      wr(ADDR_SPARE_PIN_WRITE, 8'h01);
      `CHK("spare", 2'b01, {spare_pin_out, spare_pin_oe})
      wr(ADDR_DEFAULT_TRIGGER, 8'h01);
      lsb = 1'b0;
      outs(TRIM_DEF, RST_STAGE_BIAS_MODES, 8'h00, 4'h0, 3'b000);
      rd(ADDR_DEFAULT_TRIGGER, 8'h00);
      rd(ADDR_INTERFACE_FORMAT, 8'h00);
   endtask
   // Hardware reset in mid-run, then the order is set again first
   task automatic t_hw_reset();
      // Sole device on its output bus, so enabling every channel stays exclusive
      wr(ADDR_CHANNEL_ENABLES, 8'h0F);
      reset = 1'b1;
      repeat (3) @(posedge clk);
      #1;
      reset = 1'b0;
      outs(TRIM_DEF, RST_STAGE_BIAS_MODES, 8'h00, 4'h0, 3'b000);
      wr(ADDR_INTERFACE_FORMAT, 8'h00);
      rd(ADDR_CHANNEL_ENABLES, 8'h00);
   endtask
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", checks, err_total);
      if (err_total == 0 && checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   initial begin
      repeat (8) @(posedge clk);
      #1;
      reset = 1'b0;
      t_defaults();
      t_write_mask();
      t_abort();
      t_lsb_soft();
      t_hw_reset();
      print_verdict();
   end
   // About forty frames of some 160 clocks; a hang stops far beyond that
   initial begin
      repeat (40000) @(posedge clk);
      err_total++;
      print_verdict();
   end
endmodule
